// ===== pspc_map.svh
// Constants and functional notes for the pipelined sram port control block
// Functional notes
// - Registered address, including two low burst bits, selects one location on rising edge.
// - Each active-low lane select, with write enable, gates its byte and parity bit.
// - Controller holds write enable low to write; sampled only while qualifier asserted.
// - Advance/load high with qualifier asserted steps the internal burst counter; code loads ADDR instead while op1 is PSPC_IDLE (after reset or a deselect).
// - Advance/load sampled low loads a fresh external address for a new access.
// - Inputs captured on rising edge; edges ignored while clock qualifier is high.
// - Selected only when first select low, second high, third low; else deselected.
// - Output enable low lets data lanes drive; high floats them as inputs.
// - Lanes float during write data phase, first cycle after deselect, and deselected; code drives read data in a write data phase right after a read.
// - All synchronous control and address inputs register on the same rising edge.
// - Burst order strap: high or floating interleaved, low linear; keep constant.
// - Negated qualifier does not deselect; it stretches the cycle, freezing state.
// - Read data comes from location addressed at the preceding rising edge.
`ifndef PSPC_MAP_SVH
`define PSPC_MAP_SVH
`define PSPC_ADDR_W 18
`define PSPC_LANES 4
`define PSPC_LANE_W 9
`define PSPC_BYTE_W 8
`define PSPC_BURST_W 2
`define PSPC_FIFO_DEPTH 16
`endif

// ===== pspc_pkg.sv
// Types for the pipelined sram port control block
`include "pspc_map.svh"
package pspc_pkg;
   typedef enum logic [1:0] {
      PSPC_IDLE = 2'b00,
      PSPC_READ = 2'b01,
      PSPC_WRITE = 2'b10
   } pspc_op_type;
endpackage : pspc_pkg

// ===== pspc_fifo_if.sv
// Valid/ready stream between the port control and its write data FIFO
`timescale 1ns/100ps
`default_nettype none
interface pspc_fifo_if #(parameter int WIDTH = 36);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : pspc_fifo_if
`default_nettype wire

// ===== pspc_fifo.sv
// Parameterised valid/ready FIFO with registered read data
`timescale 1ns/100ps
`default_nettype none
module pspc_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Fill side
   pspc_fifo_if.snk wr,
   // Drain side
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [WIDTH-1:0] rd_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
      logic [WIDTH-1:0] out;
      logic out_v;
   } pspc_fifo_st_type;
   logic [WIDTH-1:0] mem_r [DEPTH];
   pspc_fifo_st_type st_r, st_nxt;
   logic full, empty, push, pop;
   assign full = (st_r.wp[AW] != st_r.rp[AW]) && (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);
   assign empty = (st_r.wp == st_r.rp);
   assign wr.ready = !full;
   assign push = wr.valid && !full;
   assign pop = !empty && (!st_r.out_v || rd_ready);
   assign rd_valid = st_r.out_v;
   assign rd_data = st_r.out;
   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.wp = st_r.wp + 1'b1;
      end
      if (rd_ready && st_r.out_v) begin
         st_nxt.out_v = 1'b0;
      end
      if (pop) begin
         st_nxt.rp = st_r.rp + 1'b1;
         st_nxt.out = mem_r[st_r.rp[AW-1:0]];
         st_nxt.out_v = 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[st_r.wp[AW-1:0]] <= wr.data;
      end
   end
endmodule : pspc_fifo
`default_nettype wire

// ===== pspc_port.sv
// Pipelined burst sram control port: input capture, burst, storage, output gating
`timescale 1ns/100ps
`default_nettype none
`include "pspc_map.svh"
module pspc_port #(
   parameter int ADDR_W = `PSPC_ADDR_W,
   parameter int LANES = `PSPC_LANES,
   parameter int LANE_W = `PSPC_LANE_W,
   parameter int DEPTH = `PSPC_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // Address and burst
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic ADVANCE_OR_LOAD,
   input wire logic BURST_ORDER_STRAP,
   // Control
   input wire logic CLOCK_QUALIFIER_N,
   input wire logic WRITE_EN_N,
   input wire logic [LANES-1:0] LANE_WRITE_SEL_N,
   input wire logic CHIP_SELECT_FIRST_N,
   input wire logic CHIP_SELECT_SECOND,
   input wire logic CHIP_SELECT_THIRD_N,
   input wire logic OUTPUT_EN_N,
   // Data and parity lanes, bit LANE_W-1 of each lane is parity
   input wire logic [LANES*LANE_W-1:0] DATA_IN,
   output logic [LANES*LANE_W-1:0] DATA_OUT,
   output logic [LANES*LANE_W-1:0] DATA_OE,
   // Write buffer status
   output logic WRITE_READY
);
   localparam int DW = LANES * LANE_W;
   localparam int BW = `PSPC_BURST_W;
   localparam int WD = 1 + LANES + ADDR_W + DW;

   typedef struct packed {
      logic strap;
      logic strap_ok;
      logic [ADDR_W-1:0] base;
      logic [BW-1:0] cnt;
      pspc_pkg::pspc_op_type op1;
      logic [ADDR_W-1:0] addr1;
      logic [LANES-1:0] lane1;
      pspc_pkg::pspc_op_type op2;
      logic [ADDR_W-1:0] addr2;
      logic [LANES-1:0] lane2;
      logic sel_prev;
      logic first_after;
      logic drive;
      logic [DW-1:0] dout;
   } pspc_st_type;

   pspc_st_type st_r, st_nxt;
   logic [DW-1:0] mem_r [2**ADDR_W];
   logic sel, adv, run;
   logic [BW-1:0] low;
   logic [ADDR_W-1:0] acc_addr;
   logic [WD-1:0] wb_data;
   logic wb_valid, wb_ready;
   pspc_fifo_if #(.WIDTH(WD)) wq ();

   assign run = !CLOCK_QUALIFIER_N;
   assign sel = !CHIP_SELECT_FIRST_N && CHIP_SELECT_SECOND && !CHIP_SELECT_THIRD_N;
   assign adv = ADVANCE_OR_LOAD && st_r.op1 != pspc_pkg::PSPC_IDLE;

   // Burst sequence from counter and load address low bits
   always_comb begin
      low = st_r.cnt + 1'b1;
      if (st_r.strap) begin
         low = st_r.base[BW-1:0] ^ low;
      end else begin
         low = st_r.base[BW-1:0] + low;
      end
   end

   // Write data phase enters the buffer one cycle after its address
   assign wq.valid = run && st_r.op1 == pspc_pkg::PSPC_WRITE;
   assign wq.data = {1'b1, st_r.lane1, st_r.addr1, DATA_IN};
   assign WRITE_READY = wq.ready;

   pspc_fifo #(.WIDTH(WD), .DEPTH(DEPTH)) u_wbuf (
      .clk(CLK),
      .nrst(NRST),
      .wr(wq),
      .rd_valid(wb_valid),
      .rd_ready(wb_ready),
      .rd_data(wb_data)
   );
   assign wb_ready = 1'b1;

   always_comb begin
      st_nxt = st_r;
      acc_addr = ADDR;
      if (!st_r.strap_ok) begin
         st_nxt.strap = BURST_ORDER_STRAP;
         st_nxt.strap_ok = 1'b1;
      end
      if (run) begin
         st_nxt.sel_prev = sel;
         st_nxt.first_after = sel && !st_r.sel_prev;
         st_nxt.op2 = st_r.op1;
         st_nxt.addr2 = st_r.addr1;
         st_nxt.lane2 = st_r.lane1;
         if (!sel) begin
            st_nxt.op1 = pspc_pkg::PSPC_IDLE;
         end else begin
            if (adv) begin
               st_nxt.cnt = st_r.cnt + 1'b1;
               acc_addr = {st_r.base[ADDR_W-1:BW], low};
            end else begin
               st_nxt.base = ADDR;
               st_nxt.cnt = '0;
               acc_addr = ADDR;
            end
            st_nxt.addr1 = acc_addr;
            if (!adv && !WRITE_EN_N) begin
               st_nxt.op1 = pspc_pkg::PSPC_WRITE;
            end else if (!adv) begin
               st_nxt.op1 = pspc_pkg::PSPC_READ;
            end
            st_nxt.lane1 = ~LANE_WRITE_SEL_N;
            if (st_nxt.op1 == pspc_pkg::PSPC_READ) begin
               st_nxt.lane1 = '0;
            end
         end
         // Read data launched from location registered one edge before
         if (st_r.op1 == pspc_pkg::PSPC_READ) begin
            st_nxt.dout = mem_r[st_r.addr1];
         end
         st_nxt.drive = st_r.op1 == pspc_pkg::PSPC_READ && sel && !st_nxt.first_after;
      end
      if (!sel && run) begin
         st_nxt.drive = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Buffered write, each lane with its parity bit
   always_ff @(posedge CLK) begin
      for (int i = 0; i < LANES; i++) begin
         if (wb_valid && wb_data[DW+ADDR_W+i]) begin
            mem_r[wb_data[DW+ADDR_W-1:DW]][i*LANE_W +: LANE_W] <= wb_data[i*LANE_W +: LANE_W];
         end
      end
   end

   assign DATA_OUT = st_r.dout;
   assign DATA_OE = {DW{st_r.drive && !OUTPUT_EN_N}};
endmodule : pspc_port
`default_nettype wire

// ===== pspc_port_checker.sv
// Assertions on the pins of the port control
`timescale 1ns/100ps
`default_nettype none
module pspc_port_checker (
   // Clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // Control
   input wire logic CLOCK_QUALIFIER_N,
   input wire logic WRITE_EN_N,
   input wire logic ADVANCE_OR_LOAD,
   input wire logic CHIP_SELECT_FIRST_N,
   input wire logic CHIP_SELECT_SECOND,
   input wire logic CHIP_SELECT_THIRD_N,
   input wire logic OUTPUT_EN_N,
   // Data
   input wire logic [35:0] DATA_OUT,
   input wire logic [35:0] DATA_OE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   wire q = !CLOCK_QUALIFIER_N;
   wire s = !CHIP_SELECT_FIRST_N && CHIP_SELECT_SECOND && !CHIP_SELECT_THIRD_N;
   wire ld = q && s && !ADVANCE_OR_LOAD;
   property p_oe; OUTPUT_EN_N |-> DATA_OE == '0; endproperty
   property p_eq; DATA_OE == '0 || DATA_OE == '1; endproperty
   property p_ds; q && !s |=> DATA_OE == '0; endproperty
   property p_em; q && !s ##1 q |=> DATA_OE == '0; endproperty
   property p_wr; ld && !WRITE_EN_N ##1 q |=> DATA_OE == '0; endproperty
   property p_rd; ld && WRITE_EN_N ##1 q && s |=> OUTPUT_EN_N || DATA_OE == '1; endproperty
   property p_fz; !q |=> $stable(DATA_OUT); endproperty
   property p_fo; !q ##1 $stable(OUTPUT_EN_N) |-> $stable(DATA_OE); endproperty
   a_oe: assert property (p_oe) else $error("drive with enable high");
   a_eq: assert property (p_eq) else $error("lane enables differ");
   a_ds: assert property (p_ds) else $error("drive when deselected");
   a_em: assert property (p_em) else $error("drive after deselect");
   a_wr: assert property (p_wr) else $error("drive in write slot");
   a_rd: assert property (p_rd) else $error("no read drive");
   a_fz: assert property (p_fz) else $error("data moved in freeze");
   a_fo: assert property (p_fo) else $error("enable moved in freeze");
   c_rd: cover property (ld && WRITE_EN_N ##1 q ##1 q);
   c_wr: cover property (ld && !WRITE_EN_N);
   c_fz: cover property (!q ##1 q && ADVANCE_OR_LOAD);
endmodule : pspc_port_checker
bind pspc_port pspc_port_checker chk (.*);
`default_nettype wire

// ===== pspc_host.sv
// Memory controller model driving the port pins
`timescale 1ns/100ps
`default_nettype none
module pspc_host (
   // Clock
   input wire logic clk,
   // Pins
   output var logic [17:0] a,
   output var logic adv,
   output var logic cq_n,
   output var logic we_n,
   output var logic [3:0] be_n,
   output var logic [2:0] cs,
   output var logic [35:0] d
);
   logic pw = '0;
   logic [35:0] pd = '0;
   initial begin
      {a, adv, cq_n, we_n, be_n, cs, d} = {18'h0, 3'h3, 4'hF, 3'h4, 36'h0};
   end
   task cyc(input logic [2:0] s, input logic w, input logic v, input logic f,
         input logic [17:0] ad, input logic [3:0] b, input logic [35:0] dd);
      @(posedge clk);
      #1;
      // Data follows its write by one cycle, else a changing pattern
      d = pw ? pd : ~d;
      {cs, we_n, adv, cq_n, a, be_n} = {s, ~w, v, f, ad, b};
      pw = w && !f && s == 3'h2;
      pd = dd;
   endtask : cyc
endmodule : pspc_host
`default_nettype wire

// ===== test_pipelined_sram_port_control.sv
// Self-checking bench for the port control
`timescale 1ns/100ps
`default_nettype none
module test_pipelined_sram_port_control;
   logic clk = '0;
   logic nrst = '0;
   logic oe_n = '0;
   logic [17:0] a;
   logic adv, cq_n, we_n;
   logic [3:0] be_n;
   logic [2:0] cs;
   logic [35:0] d, dout, doe;
   logic wrdy;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   logic prev_q = '0;
   logic [36:0] q[$];
   logic [36:0] e;
   initial begin
      forever #4 clk = ~clk;
   end
   pspc_host host (.clk(clk), .a(a), .adv(adv), .cq_n(cq_n), .we_n(we_n), .be_n(be_n),
      .cs(cs), .d(d));
   pspc_port uut (.CLK(clk), .NRST(nrst), .ADDR(a), .ADVANCE_OR_LOAD(adv),
      .BURST_ORDER_STRAP(1'h1), .CLOCK_QUALIFIER_N(cq_n), .WRITE_EN_N(we_n),
      .LANE_WRITE_SEL_N(be_n), .CHIP_SELECT_FIRST_N(cs[2]), .CHIP_SELECT_SECOND(cs[1]),
      .CHIP_SELECT_THIRD_N(cs[0]), .OUTPUT_EN_N(oe_n), .DATA_IN(d), .DATA_OUT(dout),
      .DATA_OE(doe), .WRITE_READY(wrdy));
   task conclude;
      $display("miscompares %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude
   // One cycle; read data is judged one qualified edge after its own
   task go(input logic [2:0] s, input logic w, input logic v, input logic f,
         input logic [17:0] ad, input logic [3:0] b, input logic [35:0] dd,
         input logic c, input logic [35:0] x);
      host.cyc(s, w, v, f, ad, b, dd);
      comparisons++;
      if (wrdy !== 1'b1) begin
         $display("MISMATCH write ready exp 1 seen %b", wrdy);
         miscompares++;
      end
      if (prev_q && q.size() == 2) begin
         e = q.pop_front();
         if (e[36] && {dout, doe} !== {e[35:0], 36'hFFFFFFFFF}) begin
            $display("MISMATCH read data exp %h seen %h oe %h", e[35:0], dout, doe);
            miscompares++;
         end
         comparisons += e[36];
      end
      if (!f) q.push_back({c, x});
      prev_q = !f;
   endtask : go
   task idle(input int n);
      repeat (n) go(3'h2, '0, '0, '0, 18'h0, 4'h0, 36'h0, '0, 36'h0);
   endtask : idle
   task t_lanes;
      go(3'h2, '1, '0, '0, 18'h10, 4'h0, 36'h123456789, '0, 36'h0);
      go(3'h2, '1, '0, '0, 18'h10, 4'hA, 36'hFEDCBA987, '0, 36'h0);
      go(3'h2, '1, '0, '0, 18'h3FFFF, 4'h0, 36'h0F0F0F0F0, '0, 36'h0);
      for (int i = 0; i < 8; i++) if (i != 2) go(i[2:0], '1, '0, '0, 18'h10, 4'h0, 36'h0, '0, 36'h0);
      idle(3);
      go(3'h2, '0, '0, '0, 18'h10, 4'h0, 36'h0, '1,
         36'hFEDCBA987 & 36'h007FC01FF | 36'h123456789 & ~36'h007FC01FF);
      go(3'h2, '0, '0, '0, 18'h3FFFF, 4'h0, 36'h0, '1, 36'h0F0F0F0F0);
      idle(3);
   endtask : t_lanes
   task t_burst;
      for (int i = 0; i < 4; i++) go(3'h2, '1, '0, '0, 18'h100 + 18'(i), 4'h0, 36'hA00 + 36'(i), '0, 36'h0);
      idle(3);
      go(3'h2, '0, '0, '0, 18'h101, 4'h0, 36'h0, '1, 36'hA01);
      go(3'h2, '0, '1, '0, 18'h0, 4'h0, 36'h0, '1, 36'hA00);
      go(3'h2, '1, '1, '1, 18'h3FFFF, 4'h0, 36'h0, '0, 36'h0);
      go(3'h2, '0, '1, '0, 18'h0, 4'h0, 36'h0, '1, 36'hA03);
      go(3'h2, '0, '1, '0, 18'h0, 4'h0, 36'h0, '1, 36'hA02);
      idle(3);
   endtask : t_burst
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         conclude();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      #1;
      nrst = '1;
      repeat (2) @(posedge clk);
      t_lanes();
      t_burst();
      oe_n = '1;
      idle(3);
      oe_n = '0;
      conclude();
   end
endmodule : test_pipelined_sram_port_control
`default_nettype wire
